// [lms_regs.sv]
// Register bank of the electronic load: measurements, targets, trip limits and latches.
// Assumes requests arrive one 16-bit register at a time from the protocol front end,
// and that measurements are averaged floats from logic on the same clock.
`timescale 1ns/100ps
module lms_regs
  import lms_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic sample_valid,
  input wire logic [31:0] meas_current,
  input wire logic [31:0] meas_voltage,
  input wire logic [31:0] meas_sense_voltage,
  input wire logic remote_sense_engaged,
  input wire logic [31:0] meas_power,
  input wire logic [31:0] meas_resistance,
  input wire lms_mode_t reg_mode,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_error,
  output logic input_connect,
  output logic overcurrent_fault,
  output logic overvoltage_fault,
  output logic overpower_fault,
  output logic undervoltage_fault,
  output logic [31:0] regulation_reference
);

  logic [31:0] value [0:NUM_VALS-1];
  logic [15:0] pend_hi;
  logic [2:0] pend_idx;
  logic pend_valid;
  logic [NUM_TRIPS-1:0] live;
  logic [NUM_TRIPS-1:0] latch;

  wire is_read = req_valid && (req_func == FC_READ);
  wire is_multi = req_valid && (req_func == FC_WRITE_MULTI);
  wire is_single = req_valid && (req_func == FC_WRITE_SINGLE);

  wire [31:0] volt_reported = remote_sense_engaged ? meas_sense_voltage : meas_voltage;

  wire [31:0] meas_word [0:NUM_MEAS-1];
  assign meas_word[0] = meas_current;
  assign meas_word[1] = volt_reported;
  assign meas_word[2] = meas_power;
  assign meas_word[3] = meas_resistance;

  wire [31:0] status_word = {{23{1'b0}}, live[TRIP_UV], 1'b0, live[TRIP_OP], live[TRIP_OV],
                             live[TRIP_OC], 4'h0};

  logic [NUM_MEAS-1:0] meas_hi_hit;
  logic [NUM_MEAS-1:0] meas_lo_hit;
  logic [NUM_VALS-1:0] rd_hi_hit;
  logic [NUM_VALS-1:0] rd_lo_hit;
  logic [NUM_VALS-1:0] wr_hi_hit;
  logic [NUM_VALS-1:0] wr_lo_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_MEAS; gi++) begin : g_meas_dec
      assign meas_hi_hit[gi] = (req_addr == MEAS_ADDR[gi]);
      assign meas_lo_hit[gi] = (req_addr == MEAS_ADDR[gi] + ADDR_LOW_HALF);
    end
    for (gi = 0; gi < NUM_VALS; gi++) begin : g_val_dec
      assign rd_hi_hit[gi] = (req_addr == VAL_RD_ADDR[gi]);
      assign rd_lo_hit[gi] = (req_addr == VAL_RD_ADDR[gi] + ADDR_LOW_HALF);
      assign wr_hi_hit[gi] = (req_addr == VAL_WR_ADDR[gi]);
      assign wr_lo_hit[gi] = (req_addr == VAL_WR_ADDR[gi] + ADDR_LOW_HALF);
    end
  endgenerate

  wire status_hi_hit = (req_addr == ADDR_STATUS);
  wire status_lo_hit = (req_addr == ADDR_STATUS + ADDR_LOW_HALF);
  wire release_hit = (req_addr == ADDR_FAULT_RELEASE);

  // Read data and write index selection.
  logic [15:0] rd_word;
  logic rd_ok;
  logic [2:0] wr_hi_idx;
  always_comb begin
    rd_word = 16'h0000;
    rd_ok = 1'b0;
    wr_hi_idx = 3'h0;
    for (int k = 0; k < NUM_MEAS; k++) begin
      if (meas_hi_hit[k]) begin
        rd_word = meas_word[k][31:16];
        rd_ok = 1'b1;
      end else if (meas_lo_hit[k]) begin
        rd_word = meas_word[k][15:0];
        rd_ok = 1'b1;
      end
    end
    for (int k = 0; k < NUM_VALS; k++) begin
      if (rd_hi_hit[k]) begin
        rd_word = value[k][31:16];
        rd_ok = 1'b1;
      end else if (rd_lo_hit[k]) begin
        rd_word = value[k][15:0];
        rd_ok = 1'b1;
      end
      if (wr_hi_hit[k]) begin
        wr_hi_idx = k[2:0];
      end
    end
    if (status_hi_hit) begin
      rd_word = status_word[31:16];
      rd_ok = 1'b1;
    end else if (status_lo_hit) begin
      rd_word = status_word[15:0];
      rd_ok = 1'b1;
    end
  end

  // upper half first, commit on lower
  wire hi_write = is_multi && (|wr_hi_hit);
  wire lo_write = is_multi && pend_valid && wr_lo_hit[pend_idx];
  wire commit = lo_write && !pend_hi[15];
  wire [31:0] commit_value = {pend_hi, req_wdata};

  // Refusing the release while any cause is live keeps the input from chattering on and off.
  // release only with no live cause
  wire release_req = is_single && release_hit && (req_wdata != 16'h0000);
  wire release_ok = release_req && !(|live);

  wire [15:0] next_rsp_data = (is_read && rd_ok) ? rd_word : 16'h0000;
  wire next_rsp_error = req_valid && !((is_read && rd_ok) || hi_write || commit || release_req);

  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
      rsp_data <= next_rsp_data;
      rsp_error <= next_rsp_error;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pend_valid <= 1'b0;
      pend_hi <= 16'h0000;
      pend_idx <= 3'h0;
    end else if (hi_write) begin
      pend_valid <= 1'b1;
      pend_hi <= req_wdata;
      pend_idx <= wr_hi_idx;
    end else if (req_valid) begin
      pend_valid <= 1'b0;
    end
  end

  // targets and limits stored on commit
  always_ff @(posedge clk) begin
    for (int k = 0; k < NUM_VALS; k++) begin
      if (srst) begin
        value[k] <= VAL_RESET[k];
      end else if (commit && pend_idx == k[2:0]) begin
        value[k] <= commit_value;
      end
    end
  end

  // Trip comparisons use the reported voltage, so engaged sense also guards the load.
  logic [NUM_TRIPS-1:0] out_of_limit;
  assign out_of_limit[TRIP_OC] = lms_float_gt(meas_current, value[IDX_OC]);
  assign out_of_limit[TRIP_OV] = lms_float_gt(volt_reported, value[IDX_OV]);
  assign out_of_limit[TRIP_OP] = lms_float_gt(meas_power, value[IDX_OP]);
  assign out_of_limit[TRIP_UV] = lms_float_gt(value[IDX_UV], volt_reported);

  generate
    for (gi = 0; gi < NUM_TRIPS; gi++) begin : g_trip
      lms_trip_detect u_detect (
        .clk(clk),
        .srst(srst),
        .sample_valid(sample_valid),
        .out_of_limit(out_of_limit[gi]),
        .active(live[gi])
      );
    end
  endgenerate

  wire [NUM_TRIPS-1:0] next_latch = live | (latch & {NUM_TRIPS{!release_ok}});

  logic [31:0] next_reference;
  always_comb begin
    case (reg_mode)
      LMS_MODE_CC: next_reference = value[IDX_CURR];
      LMS_MODE_CV: next_reference = value[IDX_VOLT];
      LMS_MODE_CP: next_reference = value[IDX_PWR];
      LMS_MODE_CR: next_reference = value[IDX_RES];
      default: next_reference = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      latch <= '0;
      input_connect <= 1'b0;
      overcurrent_fault <= 1'b0;
      overvoltage_fault <= 1'b0;
      overpower_fault <= 1'b0;
      undervoltage_fault <= 1'b0;
      regulation_reference <= 32'h0000_0000;
    end else begin
      latch <= next_latch;
      input_connect <= !(|next_latch);
      overcurrent_fault <= next_latch[TRIP_OC];
      overvoltage_fault <= next_latch[TRIP_OV];
      overpower_fault <= next_latch[TRIP_OP];
      undervoltage_fault <= next_latch[TRIP_UV];
      regulation_reference <= next_reference;
    end
  end

  sequence s_hi_write;
    is_multi && (|wr_hi_hit);
  endsequence

  sequence s_lo_write_pos;
    is_multi && (|wr_lo_hit) && !req_wdata[15] && !pend_hi[15];
  endsequence

  a_current_read: assert property (@(posedge clk) disable iff (srst)
    is_read && meas_hi_hit[0] |=> rsp_valid && rsp_data == $past(meas_current[31:16]))
    else $error("current read returned wrong word");

  a_voltage_read: assert property (@(posedge clk) disable iff (srst)
    is_read && meas_lo_hit[1] |=> rsp_data == $past(volt_reported[15:0]))
    else $error("voltage read returned wrong word");

  a_sense_select: assert property (@(posedge clk) disable iff (srst)
    is_read && meas_hi_hit[1] && remote_sense_engaged
      |=> rsp_data == $past(meas_sense_voltage[31:16]))
    else $error("engaged sense not reported");

  a_power_read: assert property (@(posedge clk) disable iff (srst)
    is_read && meas_hi_hit[2] |=> !rsp_error && rsp_data == $past(meas_power[31:16]))
    else $error("power read returned wrong word");

  a_bad_func: assert property (@(posedge clk) disable iff (srst)
    req_valid && req_func != FC_READ && (|meas_hi_hit) |=> rsp_valid && rsp_error)
    else $error("measurement accessed with wrong code not refused");

  a_pair_commit: assert property (@(posedge clk) disable iff (srst)
    s_hi_write ##1 (s_lo_write_pos and (wr_lo_hit[pend_idx]))
      |=> value[$past(pend_idx)] == {$past(pend_hi), $past(req_wdata)})
    else $error("two-register write did not commit");

  a_cv_reference: assert property (@(posedge clk) disable iff (srst)
    reg_mode == LMS_MODE_CV ##1 reg_mode == LMS_MODE_CV
      |-> regulation_reference == $past(value[IDX_VOLT]))
    else $error("voltage reference not applied");

  a_cp_reference: assert property (@(posedge clk) disable iff (srst)
    reg_mode == LMS_MODE_CP ##1 reg_mode == LMS_MODE_CP
      |-> regulation_reference == $past(value[IDX_PWR]))
    else $error("power reference not applied");

  a_oc_trip_off: assert property (@(posedge clk) disable iff (srst)
    live[TRIP_OC] |=> !input_connect && overcurrent_fault)
    else $error("over-current trip did not disconnect");

  a_ov_trip_off: assert property (@(posedge clk) disable iff (srst)
    live[TRIP_OV] |=> !input_connect && overvoltage_fault)
    else $error("over-voltage trip did not disconnect");

  a_op_trip_off: assert property (@(posedge clk) disable iff (srst)
    live[TRIP_OP] |=> !input_connect && overpower_fault)
    else $error("over-power trip did not disconnect");

  a_uv_trip_off: assert property (@(posedge clk) disable iff (srst)
    live[TRIP_UV] |=> !input_connect && undervoltage_fault)
    else $error("under-voltage trip did not disconnect");

  a_release_blocked: assert property (@(posedge clk) disable iff (srst)
    release_req && (|live) && latch[TRIP_OV] |=> overvoltage_fault)
    else $error("latch released while a cause was live");

  a_release_done: assert property (@(posedge clk) disable iff (srst)
    release_ok |=> input_connect && !overcurrent_fault && !undervoltage_fault)
    else $error("accepted release did not reconnect");

  a_status_live: assert property (@(posedge clk) disable iff (srst)
    is_read && status_lo_hit |=> rsp_data[ST_OP_BIT] == $past(live[TRIP_OP]))
    else $error("status word does not show live power trip");

endmodule : lms_regs

// [lms_pkg.sv]
// Constants, types and helper functions for the load register bank.
// Assumes one 20 MHz clock domain and a synchronous active-high reset.
//
// Function
// - A read of the current measurement address returns the averaged terminal current.
// - A read of the voltage measurement address returns the averaged terminal voltage.
// - With remote sense in use and engaged, the voltage read reports the sense terminals.
// - The power and resistance measurement addresses each return their measured value.
// - Measurement and readback words are read with code 0x03 as two registers of a float.
// - The current target is written with code 0x10 as two registers and read back.
// - The voltage target is stored, read back, and used as reference in voltage mode.
// - The power target is stored, read back, and used as reference in power mode.
// - The resistance target is stored, read back, and used as reference in resistance mode.
// - Current above its trip limit for several samples disconnects the input with a fault.
// - Voltage above its trip limit for several samples disconnects the input with a fault.
// - Power above its trip limit for several samples disconnects the input with a fault.
// - Voltage below its trip limit for several samples disconnects the input with a fault.
// - A trip latch keeps the input off until a release write with no cause still present.
// - Live trip conditions show as bits of a read-only status word that reads do not clear.
package lms_pkg;

  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;

  localparam logic [15:0] ADDR_STATUS = 16'h10D0;
  localparam logic [15:0] ADDR_FAULT_RELEASE = 16'h10E0;
  localparam logic [15:0] ADDR_LOW_HALF = 16'h0001;

  localparam int NUM_MEAS = 4;
  localparam int NUM_VALS = 8;
  localparam int NUM_TRIPS = 4;

  localparam logic [15:0] MEAS_ADDR [0:3] = '{16'h2010, 16'h2020, 16'h2030, 16'h2040};
  localparam logic [15:0] VAL_WR_ADDR [0:7] = '{16'h3010, 16'h3030, 16'h3050, 16'h3070,
                                                16'h4010, 16'h4030, 16'h4050, 16'h4070};
  localparam logic [15:0] VAL_RD_ADDR [0:7] = '{16'h3020, 16'h3040, 16'h3060, 16'h3080,
                                                16'h4020, 16'h4040, 16'h4060, 16'h4080};

  // Upper limits reset to +infinity and the lower one to zero, so nothing trips before setup.
  localparam logic [31:0] VAL_RESET [0:7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                              32'h0000_0000, 32'h7F80_0000, 32'h7F80_0000,
                                              32'h7F80_0000, 32'h0000_0000};

  localparam int IDX_CURR = 0;
  localparam int IDX_VOLT = 1;
  localparam int IDX_PWR = 2;
  localparam int IDX_RES = 3;
  localparam int IDX_OC = 4;
  localparam int IDX_OV = 5;
  localparam int IDX_OP = 6;
  localparam int IDX_UV = 7;

  localparam int TRIP_OC = 0;
  localparam int TRIP_OV = 1;
  localparam int TRIP_OP = 2;
  localparam int TRIP_UV = 3;

  localparam int ST_OC_BIT = 4;
  localparam int ST_OV_BIT = 5;
  localparam int ST_OP_BIT = 6;
  localparam int ST_UV_BIT = 8;

  localparam int TRIP_CNT_W = 4;
  localparam logic [3:0] TRIP_SAMPLES = 4'h3;

  typedef enum logic [3:0] {
    LMS_MODE_CC = 4'h1,
    LMS_MODE_CV = 4'h2,
    LMS_MODE_CP = 4'h4,
    LMS_MODE_CR = 4'h8
  } lms_mode_t;

  // Ordered compare of two single-precision floats; NaN is not handled.
  function automatic logic lms_float_gt(input logic [31:0] a, input logic [31:0] b);
    logic res;
    res = 1'b0;
    if (a[31] != b[31]) begin
      res = !a[31] && (a[30:0] != 31'h0000_0000 || b[30:0] != 31'h0000_0000);
    end else if (!a[31]) begin
      res = a[30:0] > b[30:0];
    end else begin
      res = a[30:0] < b[30:0];
    end
    return res;
  endfunction : lms_float_gt

endpackage : lms_pkg

// [lms_trip_detect.sv]
// Consecutive-sample qualifier for one protection trip.
// Assumes the compare result and sample strobe come from logic on the same clock.
`timescale 1ns/100ps
module lms_trip_detect
  import lms_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sample_valid,
  input wire logic out_of_limit,
  output logic active
);

  logic [TRIP_CNT_W-1:0] count;
  logic [TRIP_CNT_W-1:0] next_count;
  logic next_active;

  assign next_count = !sample_valid ? count :
                      !out_of_limit ? '0 :
                      (count == TRIP_SAMPLES) ? count : count + 4'h1;
  assign next_active = (next_count == TRIP_SAMPLES);

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
      active <= 1'b0;
    end else begin
      count <= next_count;
      active <= next_active;
    end
  end

  a_trip_needs_bad: assert property (@(posedge clk) disable iff (srst)
    $rose(active) |-> $past(sample_valid && out_of_limit))
    else $error("trip rose without an out-of-limit sample");

  a_good_sample_clears: assert property (@(posedge clk) disable iff (srst)
    sample_valid && !out_of_limit |=> !active)
    else $error("trip stayed active after a good sample");

endmodule : lms_trip_detect

// [lms_host.sv]
// Host model of the register port: one 16-bit access per cycle, answer sampled a cycle later.
// Assumes the bench clock and a registered one-cycle answer from the register bank.
`timescale 1ns/100ps
module lms_host
  import lms_pkg::*;
(
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_error,
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata
);
  int miss = 0;

  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end

  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    if (rsp_valid !== 1'b1) begin
      miss++;
    end
    q = rsp_data;
    e = rsp_error;
  endtask : xfer

  // Released address and data lines show the inverse, so a stale value is never taken for a live one.
  task automatic idle();
    req_valid = 1'b0;
    req_addr = ~req_addr;
    req_wdata = ~req_wdata;
    @(negedge clk);
    if (rsp_valid !== 1'b0) begin
      miss++;
    end
  endtask : idle

  task automatic rd32(input logic [15:0] b, output logic [31:0] v, output logic e);
    logic e2;
    xfer(FC_READ, b, 16'h0000, v[31:16], e);
    xfer(FC_READ, b + ADDR_LOW_HALF, 16'h0000, v[15:0], e2);
    idle();
    e = e | e2;
  endtask : rd32

  task automatic wr32(input logic [15:0] b, input logic [31:0] v, output logic e);
    logic [15:0] q;
    logic e2;
    xfer(FC_WRITE_MULTI, b, v[31:16], q, e);
    xfer(FC_WRITE_MULTI, b + ADDR_LOW_HALF, v[15:0], q, e2);
    idle();
    e = e | e2;
  endtask : wr32

endmodule : lms_host

// [test_load_meas_setpoint_trip_regs.sv]
// Self-checking bench of the load register bank, driven through the host model.
// Assumes a 20 MHz clock and inputs changed only at the falling edge.
`timescale 1ns/100ps
module test_load_meas_setpoint_trip_regs
  import lms_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, sample_valid = 1'b0, remote_sense_engaged = 1'b0;
  logic [31:0] meas_current = 32'h3F80_0000, meas_voltage = 32'h4120_0000;
  logic [31:0] meas_sense_voltage = 32'h4120_0000, meas_power = 32'h3F80_0000;
  logic [31:0] meas_resistance = 32'h3F80_0000, regulation_reference, v;
  lms_mode_t reg_mode = LMS_MODE_CC;
  logic req_valid, rsp_valid, rsp_error, input_connect, e;
  logic [7:0] req_func;
  logic [15:0] req_addr, req_wdata, rsp_data, q;
  logic [3:0] fault;
  int error_cnt = 0, checks_done = 0;
  int st_bit [4] = '{ST_OC_BIT, ST_OV_BIT, ST_OP_BIT, ST_UV_BIT};
  lms_mode_t modes [4] = '{LMS_MODE_CC, LMS_MODE_CV, LMS_MODE_CP, LMS_MODE_CR};

  lms_regs u_dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_wdata(req_wdata), .sample_valid(sample_valid),
    .meas_current(meas_current), .meas_voltage(meas_voltage),
    .meas_sense_voltage(meas_sense_voltage), .remote_sense_engaged(remote_sense_engaged),
    .meas_power(meas_power), .meas_resistance(meas_resistance), .reg_mode(reg_mode),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
    .input_connect(input_connect), .overcurrent_fault(fault[0]),
    .overvoltage_fault(fault[1]), .overpower_fault(fault[2]),
    .undervoltage_fault(fault[3]), .regulation_reference(regulation_reference));

  lms_host u_host (.clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .req_valid(req_valid), .req_func(req_func),
    .req_addr(req_addr), .req_wdata(req_wdata));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string s);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask : chk_bit

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic t_reset();
    for (int i = 0; i < NUM_VALS; i++) begin
      u_host.rd32(VAL_RD_ADDR[i], v, e);
      chk_word(v, VAL_RESET[i], "reset value");
    end
    chk_bit(input_connect, 1'b1, "connect after reset");
    chk_bit(|fault, 1'b0, "fault after reset");
    u_host.rd32(VAL_WR_ADDR[0], v, e);
    chk_bit(e, 1'b1, "read of write-only");
    u_host.rd32(16'h2050, v, e);
    chk_bit(e, 1'b1, "unmapped read");
    u_host.wr32(MEAS_ADDR[0], 32'h3F80_0000, e);
    chk_bit(e, 1'b1, "write to measurement");
    u_host.wr32(ADDR_STATUS, 32'h0000_0000, e);
    chk_bit(e, 1'b1, "write to status");
    u_host.xfer(FC_WRITE_MULTI, VAL_WR_ADDR[0] + ADDR_LOW_HALF, 16'h1111, q, e);
    u_host.idle();
    chk_bit(e, 1'b1, "lone lower half");
    u_host.rd32(VAL_RD_ADDR[0], v, e);
    chk_word(v, 32'h0000_0000, "lone half kept out");
    $display("test reset done");
  endtask : t_reset

  task automatic t_meas();
    logic [31:0] exp [4] = '{32'h4120_0000, 32'h4148_0000, 32'h4170_0000, 32'h4180_0000};
    meas_current = exp[0];
    meas_voltage = exp[1];
    meas_sense_voltage = 32'h4150_0000;
    meas_power = exp[2];
    meas_resistance = exp[3];
    for (int i = 0; i < NUM_MEAS; i++) begin
      u_host.rd32(MEAS_ADDR[i], v, e);
      chk_word(v, exp[i], "measurement");
      chk_bit(e, 1'b0, "measurement error");
    end
    remote_sense_engaged = 1'b1;
    u_host.rd32(MEAS_ADDR[1], v, e);
    chk_word(v, 32'h4150_0000, "sensed voltage");
    remote_sense_engaged = 1'b0;
    meas_voltage = 32'h4120_0000;
    meas_sense_voltage = 32'h4120_0000;
    $display("test meas done");
  endtask : t_meas

  task automatic t_targets();
    for (int i = 0; i < NUM_VALS; i++) begin
      u_host.wr32(VAL_WR_ADDR[i], {16'h4100 + 16'(i), 16'h5A5A}, e);
      chk_bit(e, 1'b0, "write error");
      u_host.rd32(VAL_RD_ADDR[i], v, e);
      chk_word(v, {16'h4100 + 16'(i), 16'h5A5A}, "readback");
    end
    for (int m = 0; m < 4; m++) begin
      reg_mode = modes[m];
      repeat (2) @(negedge clk);
      chk_word(regulation_reference, {16'h4100 + 16'(m), 16'h5A5A}, "ref");
    end
    reg_mode = lms_mode_t'(4'h3);
    repeat (2) @(negedge clk);
    chk_word(regulation_reference, 32'h0000_0000, "ref bad mode");
    reg_mode = LMS_MODE_CC;
    u_host.wr32(VAL_WR_ADDR[0], 32'hBF80_0000, e);
    chk_bit(e, 1'b1, "negative refused");
    u_host.rd32(VAL_RD_ADDR[0], v, e);
    chk_word(v, 32'h4100_5A5A, "negative kept out");
    for (int i = IDX_OC; i < NUM_VALS; i++) begin
      u_host.wr32(VAL_WR_ADDR[i], VAL_RESET[i], e);
    end
    $display("test targets done");
  endtask : t_targets

  task automatic set_meas(input int k, input logic [31:0] x);
    case (k)
      0: meas_current = x;
      2: meas_power = x;
      default: begin
        meas_voltage = x;
        meas_sense_voltage = x;
      end
    endcase
  endtask : set_meas

  task automatic pulse(input int k, input logic [31:0] x, input int n);
    set_meas(k, x);
    repeat (n) begin
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
      @(negedge clk);
    end
  endtask : pulse

  task automatic t_trip(input int k);
    logic [31:0] bad, good;
    bad = (k == 3) ? 32'h3F80_0000 : 32'h4120_0000;
    good = (k == 3) ? 32'h4120_0000 : 32'h3F80_0000;
    u_host.wr32(VAL_WR_ADDR[IDX_OC + k], 32'h40A0_0000, e);
    pulse(k, bad, int'(TRIP_SAMPLES) - 1);
    pulse(k, good, 1);
    pulse(k, bad, int'(TRIP_SAMPLES) - 1);
    chk_bit(fault[k], 1'b0, "early trip");
    pulse(k, bad, 1);
    chk_bit(fault[k], 1'b1, "trip fault");
    chk_bit(input_connect, 1'b0, "trip disconnect");
    repeat (2) begin
      u_host.rd32(ADDR_STATUS, v, e);
      chk_word(v, 32'h1 << st_bit[k], "live bit");
    end
    u_host.xfer(FC_WRITE_SINGLE, ADDR_FAULT_RELEASE, 16'h0001, q, e);
    u_host.idle();
    chk_bit(e, 1'b0, "release error");
    chk_bit(fault[k], 1'b1, "release while live");
    pulse(k, good, 1);
    u_host.rd32(ADDR_STATUS, v, e);
    chk_word(v, 32'h0000_0000, "live cleared");
    chk_bit(fault[k], 1'b1, "latch held");
    u_host.xfer(FC_WRITE_SINGLE, ADDR_FAULT_RELEASE, 16'h0001, q, e);
    u_host.idle();
    @(negedge clk);
    chk_bit(fault[k], 1'b0, "released");
    chk_bit(input_connect, 1'b1, "reconnect");
    u_host.wr32(VAL_WR_ADDR[IDX_OC + k], VAL_RESET[IDX_OC + k], e);
    $display("test trip %0d done", k);
  endtask : t_trip

  initial begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_reset();
    t_meas();
    t_targets();
    for (int k = 0; k < NUM_TRIPS; k++) begin
      t_trip(k);
    end
    chk_word(32'(u_host.miss), 32'h0000_0000, "answer timing");
    give_verdict();
  end

  initial begin
    #2000000;
    error_cnt++;
    $display("[FAIL] %0t run did not finish", $time);
    give_verdict();
  end

endmodule : test_load_meas_setpoint_trip_regs
